// ===== rtl/pdsc_ctrl.sv
// Power-down mode control, module-standby registers and their AXI4-Lite slave.
// Assumes cpu_sleep_exec and cpu_irq_pending come from logic on aclk;
// ext_wake_pin and hw_standby_n_pin are raw pins and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module pdsc_ctrl
  import pdsc_pkg::*;
#(
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_8K = pdsc_pkg::PDSC_STL_8K,
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_16K = pdsc_pkg::PDSC_STL_16K,
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_32K = pdsc_pkg::PDSC_STL_32K,
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_64K = pdsc_pkg::PDSC_STL_64K,
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_128K = pdsc_pkg::PDSC_STL_128K,
  parameter logic [pdsc_pkg::PDSC_CW-1:0] STL_256K = pdsc_pkg::PDSC_STL_256K
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [pdsc_pkg::PDSC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [pdsc_pkg::PDSC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU side
  input wire logic cpu_sleep_exec,
  input wire logic cpu_irq_pending,
  output logic cpu_halt,
  output logic irq_exc_start,
  // Pins
  input wire logic ext_wake_pin,
  input wire logic hw_standby_n_pin,
  // Clock generator
  output logic osc_enable,
  output logic clk_supply_en,
  output logic clk_out_en,
  // Bus pins and peripherals
  output pdsc_pkg::pdsc_buspin_s bus_pin,
  output pdsc_pkg::pdsc_mstby_s mod_standby,
  output logic [7:0] mod_reinit
);
  typedef struct packed {
    pdsc_state_e st;
    logic [7:0] pdc;
    logic [7:0] sch;
    logic [7:0] scl;
    logic aw_got;
    logic [PDSC_AW-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] wake_sy;
    logic [1:0] hws_sy;
    logic exc_start;
    logic [7:0] reinit;
    logic tmr_start;
    logic [PDSC_CW-1:0] tmr_load;
  } pdsc_core_s;

  localparam pdsc_core_s CORE_RST = '{
    st: PDSC_ST_RUN,
    pdc: PDSC_PDC_RST,
    sch: PDSC_SCH_RST,
    scl: PDSC_SCL_RST,
    hws_sy: 2'b11,
    default: '0
  };

  pdsc_core_s r;
  pdsc_core_s nxt;
  logic tmr_busy;
  logic tmr_done;
  logic hws_active;
  logic wake_sync;
  logic wr_commit;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [7:0] mask_old;
  logic [7:0] mask_new;

  function automatic logic [PDSC_CW-1:0] settle_count(input logic [2:0] code);
    case (code)
      3'b000: settle_count = STL_8K;
      3'b001: settle_count = STL_16K;
      3'b010: settle_count = STL_32K;
      3'b011: settle_count = STL_64K;
      3'b100: settle_count = STL_128K;
      3'b101: settle_count = STL_256K;
      3'b110: settle_count = PDSC_STL_1K;
      // Illegal code: fall back to the longest wait so the clock is never released early
      default: settle_count = STL_256K;
    endcase
  endfunction

  // Standby-bit vector in one order for both registers: ser2..0, dma, dram, t16, t8a, t8b; adc is left out
  function automatic logic [7:0] standby_bits(input logic [7:0] sch, input logic [7:0] scl);
    standby_bits = {sch[2:0], scl[7], scl[5], scl[4], scl[3], scl[2]};
  endfunction

  assign hws_active = !r.hws_sy[1];
  assign wake_sync = r.wake_sy[1];
  assign wr_commit = r.aw_got && r.w_got && !r.bvalid;
  assign wr_sel = pdsc_decode(r.aw_addr);
  assign rd_sel = pdsc_decode(s_axi_araddr);

  always_comb
  begin
    nxt = r;
    nxt.exc_start = 1'b0;
    nxt.tmr_start = 1'b0;
    nxt.reinit = 8'h00;
    nxt.wake_sy = {r.wake_sy[0], ext_wake_pin};
    nxt.hws_sy = {r.hws_sy[0], hw_standby_n_pin};
    mask_old = standby_bits(r.sch, r.scl);
    mask_new = mask_old;

    // AXI write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt.aw_got = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt.w_got = 1'b1;
      nxt.w_data = s_axi_wdata[7:0];
      nxt.w_en = s_axi_wstrb[0];
    end
    if (wr_commit)
    begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = (wr_sel == 3'h4) ? PDSC_RESP_SLVERR : PDSC_RESP_OKAY;
      if (r.w_en)
      begin
        // Only software writes change standby-select
        if (wr_sel == 3'h0)
          nxt.pdc = r.w_data;
        else if (wr_sel == 3'h1)
          nxt.sch = r.w_data | PDSC_SCH_FIXED;
        else if (wr_sel == 3'h2)
          nxt.scl = r.w_data;
      end
    end
    else if (r.bvalid && s_axi_bready)
      nxt.bvalid = 1'b0;

    // AXI read
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt.rvalid = 1'b1;
      nxt.rresp = PDSC_RESP_OKAY;
      if (rd_sel == 3'h0)
        nxt.rdata = {24'h000000, r.pdc};
      else if (rd_sel == 3'h1)
        nxt.rdata = {24'h000000, r.sch};
      else if (rd_sel == 3'h2)
        nxt.rdata = {24'h000000, r.scl};
      else if (rd_sel == 3'h3)
        nxt.rdata = {23'h000000, tmr_busy, 5'h00, r.st};
      else
      begin
        nxt.rdata = 32'h00000000;
        nxt.rresp = PDSC_RESP_SLVERR;
      end
    end
    else if (r.rvalid && s_axi_rready)
      nxt.rvalid = 1'b0;

    // Hardware standby reinitialises both standby registers
    if (hws_active)
    begin
      nxt.sch = PDSC_SCH_RST;
      nxt.scl = PDSC_SCL_RST;
    end

    // A peripheral other than the ADC whose standby bit rises gets a reinitialise pulse
    mask_new = standby_bits(nxt.sch, nxt.scl);
    nxt.reinit = mask_new & ~mask_old;

    // Mode sequencing
    case (r.st)
      PDSC_ST_RUN:
      begin
        if (cpu_sleep_exec)
        begin
          if (r.pdc[PDSC_PDC_STANDBY_SELECT])
            nxt.st = PDSC_ST_SWSTBY;
          else
            nxt.st = PDSC_ST_SLEEP;
        end
      end
      PDSC_ST_SLEEP:
      begin
        if (cpu_irq_pending)
        begin
          nxt.st = PDSC_ST_RUN;
          nxt.exc_start = 1'b1;
        end
      end
      PDSC_ST_SWSTBY:
      begin
        // Oscillator restarts and the settling count starts together
        if (wake_sync)
        begin
          nxt.st = PDSC_ST_SETTLE;
          nxt.tmr_start = 1'b1;
          nxt.tmr_load = settle_count(r.pdc[PDSC_PDC_STS_LSB+:3]);
        end
      end
      PDSC_ST_SETTLE:
      begin
        if (tmr_done)
        begin
          nxt.st = PDSC_ST_RUN;
          nxt.exc_start = 1'b1;
        end
      end
      PDSC_ST_HWSTBY:
      begin
        nxt.st = PDSC_ST_RUN;
      end
      default:
      begin
        nxt.st = PDSC_ST_RUN;
      end
    endcase
    // Hardware standby overrides every mode and holds until the pin is released
    if (hws_active)
    begin
      nxt.st = PDSC_ST_HWSTBY;
      nxt.exc_start = 1'b0;
      nxt.tmr_start = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= CORE_RST;
    else
      r <= nxt;
  end

  pdsc_settle_timer u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(r.tmr_start),
    .load(r.tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Bus handshake
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // Mode outputs
  assign cpu_halt = (r.st != PDSC_ST_RUN);
  assign irq_exc_start = r.exc_start;
  assign osc_enable = (r.st != PDSC_ST_SWSTBY) && (r.st != PDSC_ST_HWSTBY);
  assign clk_supply_en = (r.st == PDSC_ST_RUN) || (r.st == PDSC_ST_SLEEP);
  assign clk_out_en = !r.sch[PDSC_SCH_CLOCK_OUTPUT_STOP] && (r.st != PDSC_ST_HWSTBY);

  // Bus pins float or hold while the clock is stopped
  always_comb
  begin
    bus_pin = '{addr_oe: 1'b1, addr_hold: 1'b0, ctrl_oe: 1'b1, ctrl_force_high: 1'b0};
    if ((r.st == PDSC_ST_SWSTBY) || (r.st == PDSC_ST_SETTLE))
    begin
      bus_pin.addr_oe = r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE];
      bus_pin.addr_hold = r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE];
      bus_pin.ctrl_oe = r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE];
      bus_pin.ctrl_force_high = r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE];
    end
    else if (r.st == PDSC_ST_HWSTBY)
    begin
      bus_pin.addr_oe = 1'b0;
      bus_pin.ctrl_oe = 1'b0;
    end
  end

  // Peripheral standby lines straight from the register bits
  assign mod_standby.serial_standby = r.sch[2:0];
  assign mod_standby.dma_standby = r.scl[7];
  assign mod_standby.dram_if_standby = r.scl[5];
  assign mod_standby.timer16_standby = r.scl[4];
  assign mod_standby.timer8_ch01_standby = r.scl[3];
  assign mod_standby.timer8_ch23_standby = r.scl[2];
  assign mod_standby.adc_standby = r.scl[0];
  assign mod_reinit = r.reinit;

  // Busy cycles of the settling count, read only by the checks below
  logic [PDSC_CW-1:0] chk_settle_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chk_settle_cnt <= '0;
    else if (r.tmr_start)
      chk_settle_cnt <= '0;
    else if (tmr_busy)
      chk_settle_cnt <= chk_settle_cnt + 19'h00001;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_sleep_entry;
    (r.st == PDSC_ST_RUN) && cpu_sleep_exec && !r.pdc[PDSC_PDC_STANDBY_SELECT] && !hws_active
      |=> (r.st == PDSC_ST_SLEEP) && cpu_halt && clk_supply_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_swstby_entry;
    (r.st == PDSC_ST_RUN) && cpu_sleep_exec && r.pdc[PDSC_PDC_STANDBY_SELECT] && !hws_active
      |=> (r.st == PDSC_ST_SWSTBY) && !osc_enable;
  endproperty
  a_swstby_entry: assert property (p_swstby_entry) else $error("standby not entered");

  property p_standby_select_kept;
    r.pdc[PDSC_PDC_STANDBY_SELECT] && !(wr_commit && r.w_en && (wr_sel == 3'h0))
      |=> r.pdc[PDSC_PDC_STANDBY_SELECT];
  endproperty
  a_standby_select_kept: assert property (p_standby_select_kept) else $error("standby select lost");

  property p_settle_len;
    tmr_done |-> (r.st == PDSC_ST_SETTLE) && (chk_settle_cnt == r.tmr_load);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settling length wrong");

  property p_settle_start;
    (r.st == PDSC_ST_SWSTBY) && wake_sync && !hws_active
      |=> r.tmr_start && (r.tmr_load == settle_count($past(r.pdc[PDSC_PDC_STS_LSB+:3])))
      ##1 tmr_busy;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settle count not started");

  property p_bus_float;
    (r.st == PDSC_ST_SWSTBY) && !r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE] |-> !bus_pin.addr_oe && !bus_pin.ctrl_oe;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus not floated");

  property p_bus_hold;
    (r.st == PDSC_ST_SWSTBY) && r.pdc[PDSC_PDC_STANDBY_OUTPUT_ENABLE]
      |-> bus_pin.addr_oe && bus_pin.addr_hold && bus_pin.ctrl_force_high;
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus not held");

  property p_fixed_ones;
    r.sch[6:3] == 4'hF;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("fixed bits changed");

  property p_hws_init;
    hws_active |=> (r.sch == PDSC_SCH_RST) && (r.scl == PDSC_SCL_RST) && (r.st == PDSC_ST_HWSTBY);
  endproperty
  a_hws_init: assert property (p_hws_init) else $error("standby registers not reset");

  property p_exit;
    (r.st == PDSC_ST_SETTLE) && tmr_done && !hws_active
      |=> (r.st == PDSC_ST_RUN) && irq_exc_start ##1 !irq_exc_start;
  endproperty
  a_exit: assert property (p_exit) else $error("standby exit wrong");

  property p_reinit;
    $rose(r.scl[7]) |-> r.reinit[4];
  endproperty
  a_reinit: assert property (p_reinit) else $error("no reinit pulse");

  c_sleep_cycle: cover property ((r.st == PDSC_ST_SLEEP) ##[1:50] irq_exc_start);
  c_settle_done: cover property ((r.st == PDSC_ST_SETTLE) && tmr_done);
  c_slverr: cover property (s_axi_bvalid && (s_axi_bresp == PDSC_RESP_SLVERR));
endmodule
`default_nettype wire

// ===== rtl/pdsc_pkg.sv
// Package for the power-down and module-standby control block.
// Assumes a single 20 MHz system clock; one state equals one clock cycle.
package pdsc_pkg;

  localparam int PDSC_AW = 4;
  localparam int PDSC_CW = 19;

  // Register byte offsets
  localparam logic [PDSC_AW-1:0] PDSC_OFF_PDC = 4'h0;
  localparam logic [PDSC_AW-1:0] PDSC_OFF_SCH = 4'h4;
  localparam logic [PDSC_AW-1:0] PDSC_OFF_SCL = 4'h8;
  localparam logic [PDSC_AW-1:0] PDSC_OFF_STAT = 4'hC;

  // Reset values
  localparam logic [7:0] PDSC_PDC_RST = 8'h09;
  localparam logic [7:0] PDSC_SCH_RST = 8'h78;
  localparam logic [7:0] PDSC_SCL_RST = 8'h00;
  localparam logic [7:0] PDSC_SCH_FIXED = 8'h78;

  // Field positions
  localparam int PDSC_PDC_STANDBY_SELECT = 7;
  localparam int PDSC_PDC_STS_LSB = 4;
  localparam int PDSC_PDC_STANDBY_OUTPUT_ENABLE = 1;
  localparam int PDSC_SCH_CLOCK_OUTPUT_STOP = 7;

  // Settling counts in states (clock cycles)
  localparam logic [PDSC_CW-1:0] PDSC_STL_8K = 19'h02000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_16K = 19'h04000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_32K = 19'h08000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_64K = 19'h10000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_128K = 19'h20000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_256K = 19'h40000;
  localparam logic [PDSC_CW-1:0] PDSC_STL_1K = 19'h00400;

  localparam logic [1:0] PDSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDSC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PDSC_ST_RUN = 3'b000,
    PDSC_ST_SLEEP = 3'b001,
    PDSC_ST_SWSTBY = 3'b010,
    PDSC_ST_SETTLE = 3'b011,
    PDSC_ST_HWSTBY = 3'b100
  } pdsc_state_e;

  // Standby lines to the peripherals
  typedef struct packed {
    logic [2:0] serial_standby;
    logic dma_standby;
    logic dram_if_standby;
    logic timer16_standby;
    logic timer8_ch01_standby;
    logic timer8_ch23_standby;
    logic adc_standby;
  } pdsc_mstby_s;

  // External bus pin control during standby
  typedef struct packed {
    logic addr_oe;
    logic addr_hold;
    logic ctrl_oe;
    logic ctrl_force_high;
  } pdsc_buspin_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [PDSC_CW-1:0] cnt;
  } pdsc_tmr_s;

  // 0..3 for a mapped register, 4 for unmapped
  function automatic logic [2:0] pdsc_decode(input logic [PDSC_AW-1:0] addr);
    if (addr == PDSC_OFF_PDC)
      pdsc_decode = 3'h0;
    else if (addr == PDSC_OFF_SCH)
      pdsc_decode = 3'h1;
    else if (addr == PDSC_OFF_SCL)
      pdsc_decode = 3'h2;
    else if (addr == PDSC_OFF_STAT)
      pdsc_decode = 3'h3;
    else
      pdsc_decode = 3'h4;
  endfunction

endpackage

// ===== rtl/pdsc_settle_timer.sv
// Oscillator settling counter.
// Assumes start is a one-cycle pulse on aclk; done pulses exactly load+1 cycles after start, after load busy cycles.
`timescale 1ns/10ps
`default_nettype none
module pdsc_settle_timer
  import pdsc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic [pdsc_pkg::PDSC_CW-1:0] load,
  // Status
  output logic busy,
  output logic done
);
  pdsc_tmr_s r;
  pdsc_tmr_s nxt;

  always_comb
  begin
    nxt = r;
    nxt.done = 1'b0;
    if (start)
    begin
      nxt.busy = 1'b1;
      nxt.cnt = load;
    end
    else if (r.busy)
    begin
      // Counts system states from restart, releases at the selected count
      if (r.cnt <= 19'h00001)
      begin
        nxt.busy = 1'b0;
        nxt.done = 1'b1;
      end
      else
        nxt.cnt = r.cnt - 19'h00001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= nxt;
  end

  assign busy = r.busy;
  assign done = r.done;
endmodule
`default_nettype wire

// ===== verification/pdsc_tb.sv
// Self-checking bench for the power-down and module-standby control block.
// Assumes pdsc_ctrl from rtl/ with pdsc_pkg compiled first; no checker file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdsc_pkg::*;
  logic aclk, aresetn;
  logic [PDSC_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cpu_sleep_exec, cpu_irq_pending, cpu_halt, irq_exc_start;
  logic ext_wake_pin, hw_standby_n_pin, osc_enable, clk_supply_en, clk_out_en;
  pdsc_buspin_s bus_pin;
  pdsc_mstby_s mod_standby;
  logic [7:0] mod_reinit;
  int fail_count, check_count;
  logic [7:0] reinit_seen;

  // Counts 001..101 shortened to 32..96 states so every code fits in one run;
  // code 000 keeps its full count. They stand in for the wait software picks
  pdsc_ctrl #(
    .STL_16K(19'h00020), .STL_32K(19'h00030),
    .STL_64K(19'h00040), .STL_128K(19'h00050), .STL_256K(19'h00060)
  ) pdsc_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_sleep_exec, .cpu_irq_pending,
    .cpu_halt, .irq_exc_start, .ext_wake_pin, .hw_standby_n_pin, .osc_enable,
    .clk_supply_en, .clk_out_en, .bus_pin, .mod_standby, .mod_reinit
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Reinitialise pulses last one cycle; collect them mid-cycle where they have settled
  always @(negedge aclk)
  begin
    if (!aresetn)
      reinit_seen <= 8'h00;
    else
      reinit_seen <= reinit_seen | mod_reinit;
  end

  task automatic end_sim;
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Address and data go out together; each drops once its own ready is seen
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      // Handshakes are judged mid-cycle, where ready has settled, and acted on at the edge
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs)
        r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
      if (b_hs)
        s_axi_bready <= 1'b0;
    end
    while (!b_hs && n < 50);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r = 2'h3;
    d = 32'hFFFFFFFF;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
      end
      @(posedge aclk);
      n++;
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
      if (r_hs)
        s_axi_rready <= 1'b0;
    end
    while (!r_hs && n < 50);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    axi_wr(a, d, rsp);
    chk(32'(rsp), 32'h0, "write response");
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
    axi_rd(a, rd, rsp);
    chk(32'(rsp), 32'h0, "read response");
    chk(rd, exp, what);
  endtask

  task automatic pulse_sleep;
    @(posedge aclk);
    cpu_sleep_exec <= 1'b1;
    @(posedge aclk);
    cpu_sleep_exec <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_reset;
    rdchk(PDSC_OFF_PDC, 32'h00000009, "control reset");
    rdchk(PDSC_OFF_SCH, 32'h00000078, "high reset");
    rdchk(PDSC_OFF_SCL, 32'h00000000, "low reset");
    rdchk(PDSC_OFF_STAT, 32'h00000000, "status idle");
    chk(32'({clk_out_en, mod_standby}), 32'h00000200, "outputs after reset");
  endtask

  task automatic t_unmapped;
    axi_wr(4'h6, 8'hFF, rsp);
    chk(32'(rsp), 32'h2, "unmapped write");
    axi_rd(4'h2, rd, rsp);
    chk({rd[29:0], rsp}, 32'h2, "unmapped read");
    s_axi_wstrb <= 4'h0;
    wr(PDSC_OFF_SCL, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rdchk(PDSC_OFF_SCL, 32'h00000000, "masked write");
  endtask

  task automatic t_high;
    wr(PDSC_OFF_SCH, 8'h87);
    rdchk(PDSC_OFF_SCH, 32'h000000FF, "high readback");
    chk(32'({clk_out_en, mod_standby.serial_standby}), 32'h7, "clock pin off");
    wr(PDSC_OFF_SCH, 8'h02);
    rdchk(PDSC_OFF_SCH, 32'h0000007A, "high fixed ones");
    chk(32'({clk_out_en, mod_standby.serial_standby}), 32'hA, "clock pin on");
  endtask

  task automatic t_low;
    wr(PDSC_OFF_SCL, 8'hBD);
    rdchk(PDSC_OFF_SCL, 32'h000000BD, "low readback");
    chk(32'(mod_standby), 32'h000000BF, "peripheral standby");
    chk(32'(reinit_seen), 32'h000000FF, "reinit pulses");
    wr(PDSC_OFF_SCL, 8'h42);
    rdchk(PDSC_OFF_SCL, 32'h00000042, "reserved storage");
    chk(32'(mod_standby), 32'h00000080, "reserved no effect");
  endtask

  task automatic t_sleep;
    int n;
    n = 0;
    wr(PDSC_OFF_PDC, 8'h00);
    pulse_sleep;
    chk(32'({cpu_halt, clk_supply_en, osc_enable}), 32'h7, "sleep entry");
    cpu_irq_pending <= 1'b1;
    while (irq_exc_start !== 1'b1 && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    cpu_irq_pending <= 1'b0;
    @(posedge aclk);
    chk(32'({n < 20, cpu_halt}), 32'h2, "sleep exit");
  endtask

  // Wait measured from oscillator restart to the exception start pulse
  task automatic t_standby(input logic [2:0] code);
    int n;
    int lim;
    logic [7:0] v;
    lim = (code == 3'h6) ? 1024 : ((code == 3'h0) ? 8192 : 16 * (int'(code) + 1));
    v = {1'b1, code, 2'b00, code[0], 1'b0};
    n = 0;
    wr(PDSC_OFF_PDC, v);
    pulse_sleep;
    chk(32'({cpu_halt, clk_supply_en, osc_enable}), 32'h4, "standby entry");
    chk(32'({bus_pin.addr_oe, bus_pin.ctrl_oe}), code[0] ? 32'h3 : 32'h0, "bus float");
    if (code[0])
      chk(32'(bus_pin), 32'hF, "bus held high");
    ext_wake_pin <= 1'b1;
    while (!osc_enable && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    while (irq_exc_start !== 1'b1 && n < 9000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= lim && n <= lim + 3), 32'h1, "settle length");
    ext_wake_pin <= 1'b0;
    @(posedge aclk);
    chk(32'({cpu_halt, clk_supply_en}), 32'h1, "clocks back");
    rdchk(PDSC_OFF_PDC, {24'h000000, v}, "select kept");
  endtask

  task automatic t_hwstby;
    hw_standby_n_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(32'(mod_standby), 32'h0, "standby cleared");
    hw_standby_n_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    rdchk(PDSC_OFF_SCH, 32'h00000078, "high after hardware standby");
    rdchk(PDSC_OFF_SCL, 32'h00000000, "low after hardware standby");
  endtask

  // Whole run is about 10000 cycles, most of it the full-length code 000 wait
  initial
  begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    end_sim;
  end

  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_sleep_exec, cpu_irq_pending, ext_wake_pin} = '0;
    hw_standby_n_pin = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_unmapped;
    t_high;
    t_low;
    t_sleep;
    for (int c = 0; c < 7; c++)
      t_standby(3'(c));
    rdchk(PDSC_OFF_SCH, 32'h0000007A, "high kept in standby");
    rdchk(PDSC_OFF_SCL, 32'h00000042, "low kept in standby");
    t_hwstby;
    end_sim;
  end
endmodule
`default_nettype wire
